// file: logic/clqo_defs.svh
// constants for the closed loop direction and pulse output block
// Operation
// - direction bit: 0 CCW forward, 1 CW
// - forward turning gives phase B leading
// - usage 0 ignores scale, semi-closed loop
// - usage 1: CCW counts scale forward
// - usage 3: CCW counts scale reverse
// - direction bit and usage pick output lead
// - pitches per turn 4..1048576, applied at restart
// - output edges per pitch 1..4096, at restart
// - alarm when x4 output exceeds 6.4 Mpps
`ifndef CLQO_DEFS_SVH
`define CLQO_DEFS_SVH

// register offsets (byte addresses)
`define CLQO_OFS_CFG 8'h00
`define CLQO_OFS_PITCH 8'h04
`define CLQO_OFS_EDGES 8'h08
`define CLQO_OFS_APPLY 8'h0C
`define CLQO_OFS_STATUS 8'h10
`define CLQO_OFS_FBCNT 8'h14
`define CLQO_OFS_PITCHPOS 8'h18
`define CLQO_OFS_IRQ_STAT 8'h1C
`define CLQO_OFS_IRQ_CLR 8'h20
`define CLQO_OFS_IRQ_EN 8'h24

// field positions
`define CLQO_CFG_DIR_BIT 0
`define CLQO_CFG_USAGE_LSB 1
`define CLQO_CFG_USAGE_MSB 3
`define CLQO_APPLY_BIT 0
`define CLQO_IRQ_OVERSPEED 0
`define CLQO_IRQ_CFG_REJECT 1
`define CLQO_IRQ_REV_MARK 2

// reset values and setting ranges
`define CLQO_DIR_RST 1'h0
`define CLQO_USAGE_RST 3'h0
`define CLQO_PITCH_RST 21'h08000
`define CLQO_PITCH_MIN 21'h00004
`define CLQO_PITCH_MAX 21'h100000
`define CLQO_EDGES_RST 13'h0014
`define CLQO_EDGES_MIN 13'h0001
`define CLQO_EDGES_MAX 13'h1000

// fine interpolation ticks per scale pitch
`define CLQO_FRAC_TICKS 14'h1000

// overspeed watch: limit in kpps, window in ns, clock period in ps
`define CLQO_CLK_PERIOD_PS 4000
`define CLQO_MAX_RATE_KPPS 6400
`define CLQO_WINDOW_NS 10000
`define CLQO_WINDOW_CYC ((`CLQO_WINDOW_NS * 1000) / `CLQO_CLK_PERIOD_PS)
`define CLQO_LIMIT_EDGES ((`CLQO_MAX_RATE_KPPS * `CLQO_WINDOW_NS) / 1000000)

`endif

// file: logic/clqo_pkg.sv
// types shared by the closed loop direction and pulse output block
package clqo_pkg;

  typedef logic [31:0] clqo_word_t;

  // external scale usage codes; other codes are reserved
  typedef enum logic [2:0] {
    CLQO_USE_NONE = 3'h0,
    CLQO_USE_FWD = 3'h1,
    CLQO_USE_REV = 3'h3
  } clqo_usage_e;

endpackage : clqo_pkg

// file: logic/clqo_top.sv
// closed loop direction select, scale usage and quadrature pulse emulation
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "clqo_defs.svh"

module clqo_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire clqo_pkg::clqo_word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output clqo_pkg::clqo_word_t rdata_o,
  // motor encoder fine increments
  input wire logic motor_tick_i,
  input wire logic motor_ccw_i,
  // external scale fine increments
  input wire logic scale_tick_i,
  input wire logic scale_cos_lead_i,
  input wire logic scale_index_i,
  // emulated encoder output
  output logic quad_out_a_o,
  output logic quad_out_b_o,
  output logic origin_out_o,
  // status
  output logic overspeed_o,
  output logic closed_loop_o,
  output logic rev_mark_o,
  output logic irq_o
);
  import clqo_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // functions
  // next A/B pair one quarter period on, forward or reverse
  function automatic logic [1:0] gray_step(input logic [1:0] ab, input logic fwd);
    logic [1:0] q;
    logic [1:0] nq;
    q = {ab[1], ab[1] ^ ab[0]};
    nq = fwd ? q + 2'h1 : q - 2'h1;
    gray_step = {nq[1], nq[1] ^ nq[0]};
  endfunction : gray_step

  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] ofs, input logic w);
    is_wr = w && (a == ofs);
  endfunction : is_wr

  //////////////////////////////////////////////////////////////////////////////
  // settings: shadow copies written by software, active copies at restart
  logic sh_dir;
  logic [2:0] sh_usage;
  logic [20:0] sh_pitch;
  logic [12:0] sh_edges;
  logic act_dir;
  clqo_usage_e act_usage;
  logic [20:0] act_pitch;
  logic [12:0] act_edges;
  logic apply_q;
  logic cfg_reject;
  logic usage_ok;
  logic pitch_ok;
  logic edges_ok;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_dir <= `CLQO_DIR_RST;
      sh_usage <= `CLQO_USAGE_RST;
      sh_pitch <= `CLQO_PITCH_RST;
      sh_edges <= `CLQO_EDGES_RST;
    end else begin
      if (is_wr(addr_i, `CLQO_OFS_CFG, wr_i)) begin
        sh_dir <= wdata_i[`CLQO_CFG_DIR_BIT];
        sh_usage <= wdata_i[`CLQO_CFG_USAGE_MSB:`CLQO_CFG_USAGE_LSB];
      end
      if (is_wr(addr_i, `CLQO_OFS_PITCH, wr_i)) begin
        sh_pitch <= wdata_i[20:0];
      end
      if (is_wr(addr_i, `CLQO_OFS_EDGES, wr_i)) begin
        sh_edges <= wdata_i[12:0];
      end
    end
  end

  // restart request: the write takes effect one cycle later
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      apply_q <= 1'b0;
    end else begin
      apply_q <= is_wr(addr_i, `CLQO_OFS_APPLY, wr_i) && wdata_i[`CLQO_APPLY_BIT];
    end
  end

  always_comb begin
    usage_ok = (sh_usage == CLQO_USE_NONE) || (sh_usage == CLQO_USE_FWD) ||
               (sh_usage == CLQO_USE_REV);
    pitch_ok = (sh_pitch >= `CLQO_PITCH_MIN) && (sh_pitch <= `CLQO_PITCH_MAX);
    edges_ok = (sh_edges >= `CLQO_EDGES_MIN) && (sh_edges <= `CLQO_EDGES_MAX);
    cfg_reject = apply_q && !(usage_ok && pitch_ok && edges_ok);
  end

  // out of range values keep the previous active setting; a reserved usage
  // code falls back to semi-closed loop so the drive never runs half set up
  // restart loading
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_dir <= `CLQO_DIR_RST;
      act_usage <= CLQO_USE_NONE;
      act_pitch <= `CLQO_PITCH_RST;
      act_edges <= `CLQO_EDGES_RST;
    end else if (apply_q) begin
      act_dir <= sh_dir;
      act_usage <= usage_ok ? clqo_usage_e'(sh_usage) : CLQO_USE_NONE;
      if (pitch_ok) begin
        act_pitch <= sh_pitch;
      end
      if (edges_ok) begin
        act_edges <= sh_edges;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // feedback source and direction
  logic closed;
  logic sel_tick;
  logic sel_ccw;
  logic step_fwd;
  always_comb begin
    closed = (act_usage != CLQO_USE_NONE);
    sel_tick = closed ? scale_tick_i : motor_tick_i;
    sel_ccw = closed ? (scale_cos_lead_i ^ (act_usage == CLQO_USE_REV)) : motor_ccw_i;
  end

  assign step_fwd = sel_ccw ^ act_dir;
  // scale position counted in the motor CCW sense; frozen in semi-closed loop
  clqo_word_t fb_count;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fb_count <= 32'h0000_0000;
    end else if (apply_q) begin
      fb_count <= 32'h0000_0000;
    end else if (closed && scale_tick_i) begin
      fb_count <= sel_ccw ? fb_count + 32'h0000_0001 : fb_count - 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge generation: act_edges output edges per FRAC_TICKS fine ticks
  logic [11:0] acc;
  logic [13:0] acc_up;
  logic [13:0] acc_dn;
  logic edge_now;
  always_comb begin
    acc_up = {2'h0, acc} + {1'h0, act_edges};
    acc_dn = {2'h0, acc} - {1'h0, act_edges};
    edge_now = sel_tick && (step_fwd ? (acc_up >= `CLQO_FRAC_TICKS) : acc_dn[13]);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc <= 12'h000;
    end else if (apply_q) begin
      acc <= 12'h000;
    end else if (sel_tick) begin
      acc <= step_fwd ? acc_up[11:0] : acc_dn[11:0];
    end
  end

  // at most one edge per tick, so no backlog can build up
  // quadrature stepping
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quad_out_a_o <= 1'b0;
      quad_out_b_o <= 1'b0;
    end else if (edge_now && !apply_q) begin
      {quad_out_a_o, quad_out_b_o} <= gray_step({quad_out_a_o, quad_out_b_o}, step_fwd);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      origin_out_o <= 1'b0;
      closed_loop_o <= 1'b0;
    end else begin
      origin_out_o <= closed && scale_index_i;
      closed_loop_o <= closed;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pitch position within one motor turn
  logic [11:0] frac;
  logic [20:0] pitch_pos;
  logic frac_wrap;
  logic rev_evt;
  always_comb begin
    frac_wrap = sel_tick && (step_fwd ? (frac == 12'hFFF) : (frac == 12'h000));
    rev_evt = frac_wrap && (step_fwd ? (pitch_pos == act_pitch - 21'h000001) :
                                       (pitch_pos == 21'h000000));
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frac <= 12'h000;
      pitch_pos <= 21'h000000;
      rev_mark_o <= 1'b0;
    end else if (apply_q) begin
      frac <= 12'h000;
      pitch_pos <= 21'h000000;
      rev_mark_o <= 1'b0;
    end else begin
      rev_mark_o <= rev_evt;
      if (sel_tick) begin
        frac <= step_fwd ? frac + 12'h001 : frac - 12'h001;
      end
      if (rev_evt) begin
        pitch_pos <= step_fwd ? 21'h000000 : act_pitch - 21'h000001;
      end else if (frac_wrap) begin
        pitch_pos <= step_fwd ? pitch_pos + 21'h000001 : pitch_pos - 21'h000001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output rate watch: edges counted over a fixed window
  logic [11:0] win_cnt;
  logic [6:0] edge_cnt;
  logic win_end;
  logic over_evt;
  always_comb begin
    win_end = (win_cnt == 12'(`CLQO_WINDOW_CYC - 1));
    over_evt = edge_now && !win_end && (edge_cnt >= 7'(`CLQO_LIMIT_EDGES));
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      win_cnt <= 12'h000;
      edge_cnt <= 7'h00;
      overspeed_o <= 1'b0;
    end else begin
      win_cnt <= win_end ? 12'h000 : win_cnt + 12'h001;
      if (win_end) begin
        edge_cnt <= {6'h00, edge_now};
      end else if (edge_now && (edge_cnt <= 7'(`CLQO_LIMIT_EDGES))) begin
        edge_cnt <= edge_cnt + 7'h01;
      end
      // the alarm holds until the next restart
      if (apply_q) begin
        overspeed_o <= 1'b0;
      end else if (over_evt) begin
        overspeed_o <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write-one clear, enable
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [2:0] next_irq_stat;
  always_comb begin
    irq_set = {rev_evt, cfg_reject, over_evt};
    irq_clr = is_wr(addr_i, `CLQO_OFS_IRQ_CLR, wr_i) ? wdata_i[2:0] : 3'h0;
    // a set in the clearing cycle wins
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat <= 3'h0;
      irq_en <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      if (is_wr(addr_i, `CLQO_OFS_IRQ_EN, wr_i)) begin
        irq_en <= wdata_i[2:0];
        irq_o <= |(next_irq_stat & wdata_i[2:0]);
      end else begin
        irq_o <= |(next_irq_stat & irq_en);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port: data stand only in the cycle after the strobe
  clqo_word_t next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        `CLQO_OFS_CFG: next_rdata = {28'h0, sh_usage, sh_dir};
        `CLQO_OFS_PITCH: next_rdata = {11'h0, sh_pitch};
        `CLQO_OFS_EDGES: next_rdata = {19'h0, sh_edges};
        `CLQO_OFS_STATUS: next_rdata = {24'h0, quad_out_b_o, quad_out_a_o, overspeed_o,
                                        closed, act_usage, act_dir};
        `CLQO_OFS_FBCNT: next_rdata = fb_count;
        `CLQO_OFS_PITCHPOS: next_rdata = {11'h0, pitch_pos};
        `CLQO_OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
        `CLQO_OFS_IRQ_EN: next_rdata = {29'h0, irq_en};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  chk_dir_forward_sense: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (!closed && motor_tick_i && edge_now && !apply_q) |=> ({quad_out_a_o, quad_out_b_o} ==
      gray_step($past({quad_out_a_o, quad_out_b_o}), $past(motor_ccw_i != act_dir))))
    else $error("forward sense does not follow the direction bit");
  chk_fwd_b_leads: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (edge_now && !apply_q && step_fwd) |=>
      ({quad_out_a_o, quad_out_b_o} == gray_step($past({quad_out_a_o, quad_out_b_o}), 1'b1)))
    else $error("forward edge did not advance phase B first");
  chk_semi_ignores_scale: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (!closed && !motor_tick_i && !apply_q) |=> ($stable(acc) && $stable(fb_count)))
    else $error("scale input moved state in semi-closed loop");
  chk_usage_fwd_count: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (act_usage == CLQO_USE_FWD && scale_tick_i && scale_cos_lead_i && !apply_q) |=>
      (fb_count == $past(fb_count) + 32'h0000_0001))
    else $error("usage 1 did not count cos lead as CCW");
  chk_usage_rev_count: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (act_usage == CLQO_USE_REV && scale_tick_i && scale_cos_lead_i && !apply_q) |=>
      (fb_count == $past(fb_count) - 32'h0000_0001))
    else $error("usage 3 did not count cos lead as CW");
  chk_lead_table: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (closed && scale_tick_i && edge_now && !apply_q) |=> ({quad_out_a_o, quad_out_b_o} ==
      gray_step($past({quad_out_a_o, quad_out_b_o}),
                $past(scale_cos_lead_i ^ (act_usage == CLQO_USE_REV) ^ act_dir))))
    else $error("output lead disagrees with direction and usage");
  chk_pitch_apply: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (apply_q && pitch_ok) |=> (act_pitch == $past(sh_pitch)) ##1 $stable(act_pitch) or apply_q)
    else $error("pitch count not taken at restart");
  chk_edges_apply: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (apply_q && !edges_ok) |=> $stable(act_edges))
    else $error("out of range edge count was accepted");
  chk_overspeed_alarm: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (over_evt && !apply_q) |=> overspeed_o ##1 (overspeed_o || $past(apply_q)))
    else $error("overspeed alarm missing or not held");
  chk_gray_one_toggle: assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    !($changed(quad_out_a_o) && $changed(quad_out_b_o)))
    else $error("both quadrature outputs toggled at once");

endmodule : clqo_top

// file: verif/clqo_host_model.sv
// host side model that counts the emulated quadrature edges
`timescale 1ns/1ps

module clqo_host_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // quadrature pair from the drive
  input wire logic quad_a_i,
  input wire logic quad_b_i,
  // position count and illegal step count
  output int pos_o,
  output int bad_o
);
  logic [1:0] prev;
  logic [1:0] cur;

  assign cur = {quad_a_i, quad_b_i};

  // forward successor of an A/B state: 00, 01, 11, 10
  function automatic logic [1:0] clqo_fwd(input logic [1:0] s);
    return {s[0], ~s[1]};
  endfunction : clqo_fwd

  ////////////////////////////////////////////////////////////////////////
  // up on B-leading steps, down on A-leading, flag double toggles
  // a real counter would lose position on a double toggle, so it is counted
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev <= 2'h0;
      pos_o <= 0;
      bad_o <= 0;
    end else begin
      prev <= cur;
      if (cur === clqo_fwd(prev)) begin
        pos_o <= pos_o + 1;
      end else if (prev === clqo_fwd(cur)) begin
        pos_o <= pos_o - 1;
      end else if (cur !== prev) begin
        bad_o <= bad_o + 1;
      end
    end
  end
endmodule : clqo_host_model

// file: verif/tb_top.sv
// self-checking bench for the closed loop pulse output block
`timescale 1ns/1ps
`include "clqo_defs.svh"

module tb_top;
  import clqo_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  clqo_word_t wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  clqo_word_t rdata_o;
  logic motor_tick_i = 1'b0;
  logic motor_ccw_i = 1'b0;
  logic scale_tick_i = 1'b0;
  logic scale_cos_lead_i = 1'b0;
  logic scale_index_i = 1'b0;
  logic quad_out_a_o, quad_out_b_o, origin_out_o;
  logic overspeed_o, closed_loop_o, rev_mark_o, irq_o;
  int error_cnt = 0;
  int n_compared = 0;
  int n_rev = 0;
  int cnt, bad, base, rv;
  clqo_word_t d;

  always #2 mclk_i = ~mclk_i;

  clqo_top clqo_top_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .motor_tick_i(motor_tick_i), .motor_ccw_i(motor_ccw_i), .scale_tick_i(scale_tick_i),
    .scale_cos_lead_i(scale_cos_lead_i), .scale_index_i(scale_index_i),
    .quad_out_a_o(quad_out_a_o), .quad_out_b_o(quad_out_b_o), .origin_out_o(origin_out_o),
    .overspeed_o(overspeed_o), .closed_loop_o(closed_loop_o), .rev_mark_o(rev_mark_o),
    .irq_o(irq_o));

  clqo_host_model clqo_host_model_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .quad_a_i(quad_out_a_o), .quad_b_i(quad_out_b_o), .pos_o(cnt), .bad_o(bad));

  // the turn mark is a single-cycle pulse, so it is counted on every edge
  always @(posedge mclk_i) if (rev_mark_o === 1'b1) n_rev <= n_rev + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input clqo_word_t seen, input clqo_word_t exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input clqo_word_t v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output clqo_word_t v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  // shadows, stale flags cleared, then restart so only fresh flags remain
  task automatic cfg(input clqo_word_t c, input clqo_word_t p, input clqo_word_t e);
    wr(`CLQO_OFS_CFG, c);
    wr(`CLQO_OFS_PITCH, p);
    wr(`CLQO_OFS_EDGES, e);
    wr(`CLQO_OFS_IRQ_CLR, 32'h7);
    wr(`CLQO_OFS_APPLY, 32'h1);
    repeat (3) @(posedge mclk_i);
    #1 base = cnt;
  endtask : cfg

  // n ticks from the scale or the motor, gap idle cycles after each one
  task automatic tk(input logic sc, input logic dv, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      motor_tick_i <= ~sc;
      scale_tick_i <= sc;
      motor_ccw_i <= dv;
      scale_cos_lead_i <= dv;
      if (gap > 0) begin
        @(posedge mclk_i);
        motor_tick_i <= 1'b0;
        scale_tick_i <= 1'b0;
        repeat (gap - 1) @(posedge mclk_i);
      end
    end
    @(posedge mclk_i);
    motor_tick_i <= 1'b0;
    scale_tick_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask : tk

  task automatic moved(input int exp);
    chk(32'(cnt - base), 32'(exp));
    base = cnt;
  endtask : moved

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(`CLQO_OFS_STATUS, d);
    chk(d, 32'h0);
    rd(`CLQO_OFS_PITCH, d);
    chk(d, 32'h8000);
    rd(`CLQO_OFS_EDGES, d);
    chk(d, 32'h14);
    rd(8'h3C, d);
    chk(d, 32'h0);
    wr(`CLQO_OFS_IRQ_EN, 32'h7);
    cfg(32'h0, 32'h8000, 32'h1000);
    tk(1'b0, 1'b1, 8, 0);
    moved(8);
    tk(1'b1, 1'b1, 8, 0);
    moved(0);
    chk(32'(closed_loop_o), 32'h0);
    cfg(32'h1, 32'h8000, 32'h1000);
    tk(1'b0, 1'b1, 8, 0);
    moved(-8);
    tk(1'b0, 1'b0, 8, 0);
    moved(8);
    for (int u = 1; u < 4; u += 2) begin
      for (int dv = 0; dv < 2; dv++) begin
        for (int c = 0; c < 2; c++) begin
          cfg(32'(u * 2 + dv), 32'h8000, 32'h1000);
          tk(1'b1, c[0], 4, 0);
          moved(((c ^ (u == 3) ^ dv) != 0) ? 4 : -4);
          rd(`CLQO_OFS_FBCNT, d);
          chk(d, ((c ^ (u == 3)) != 0) ? 32'h4 : 32'hFFFF_FFFC);
          tk(1'b0, 1'b1, 4, 0);
          moved(0);
          chk(32'(closed_loop_o), 32'h1);
          rd(`CLQO_OFS_STATUS, d);
          chk(d & 32'h1F, 32'(16 + u * 2 + dv));
        end
      end
    end
    // reserved usage codes with out-of-range counts must be refused
    for (int r = 2; r < 5; r += 2) begin
      cfg(32'(r * 2), 32'h3, 32'h0);
      rd(`CLQO_OFS_STATUS, d);
      chk(d & 32'hF, 32'h0);
      rd(`CLQO_OFS_IRQ_STAT, d);
      chk(d & 32'h2, 32'h2);
      chk(32'(irq_o), 32'h1);
      wr(`CLQO_OFS_IRQ_CLR, 32'h2);
      repeat (2) @(posedge mclk_i);
      #1 chk(32'(irq_o), 32'h0);
      tk(1'b0, 1'b1, 4, 0);
      moved(4);
    end
    // edges from the earlier scenarios share the rate window; let a fresh one open
    repeat (`CLQO_WINDOW_CYC) @(posedge mclk_i);
    cfg(32'h0, 32'h8000, 32'h1000);
    tk(1'b0, 1'b1, 100, 39);
    chk(32'(overspeed_o), 32'h0);
    tk(1'b0, 1'b1, 200, 0);
    chk(32'(overspeed_o), 32'h1);
    rd(`CLQO_OFS_IRQ_STAT, d);
    chk(d & 32'h1, 32'h1);
    cfg(32'h0, 32'h8000, 32'd20);
    chk(32'(overspeed_o), 32'h0);
    tk(1'b0, 1'b1, 4100, 0);
    moved(20);
    cfg(32'h2, 32'h4, 32'h1);
    rv = n_rev;
    tk(1'b1, 1'b1, 16484, 0);
    moved(4);
    chk(32'(n_rev - rv), 32'h1);
    rd(`CLQO_OFS_FBCNT, d);
    chk(d, 32'h4064);
    rd(`CLQO_OFS_IRQ_STAT, d);
    chk(d & 32'h4, 32'h4);
    @(posedge mclk_i);
    scale_index_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 chk(32'(origin_out_o), 32'h1);
    cfg(32'h0, 32'h8000, 32'h1000);
    chk(32'(origin_out_o), 32'h0);
    chk(32'(bad), 32'h0);
    end_of_test();
  end

  // the sequence needs about 30000 cycles, so this leaves ample margin
  initial begin
    repeat (100000) @(posedge mclk_i);
    error_cnt++;
    end_of_test();
  end
endmodule : tb_top
